// ===== core/flash_bus_cycle.sv
// One asynchronous memory bus cycle (read or write) on the flash pins.
// Assumes the caller holds address and data stable while busy is high.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.svh"
module flash_bus_cycle #(
   parameter int ADDR_W = 17,
   parameter int STROBE = `STROBE_CYC,
   parameter int SETUP  = `SETUP_CYC
) (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              start,
   input  wire logic              isWrite,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   input  wire logic [7:0]        pinDataIn,
   output logic [ADDR_W-1:0]      pinAddr,
   output logic [7:0]             pinDataOut,
   output logic                   pinDataOe,
   output logic                   chipEn_n,
   output logic                   outEn_n,
   output logic                   writeEn_n,
   output logic                   busy,
   output logic                   done,
   output logic [7:0]             rdata
);
   logic [7:0] count;
   logic [1:0] phase;

   // Setup, strobe, hold phases of one bus cycle
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         pinAddr    <= '0;
         pinDataOut <= 8'h00;
         pinDataOe  <= 1'b0;
         chipEn_n   <= 1'b1;
         outEn_n    <= 1'b1;
         writeEn_n  <= 1'b1;
         busy       <= 1'b0;
         done       <= 1'b0;
         rdata      <= 8'h00;
         count      <= 8'h00;
         phase      <= 2'h0;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               busy       <= 1'b1;
               pinAddr    <= addr;
               pinDataOut <= wdata;
               pinDataOe  <= isWrite;
               chipEn_n   <= 1'b0;
               outEn_n    <= isWrite;
               phase      <= 2'h0;
               count      <= 8'(SETUP);
            end
         end else if (count != 8'h00) begin
            count <= count - 8'h01;
         end else begin
            case (phase)
               2'h0: begin
                  // Address is latched by the device on this falling strobe
                  writeEn_n <= ~pinDataOe;
                  phase     <= 2'h1;
                  count     <= 8'(STROBE);
               end
               2'h1: begin
                  // Data is latched on the rising strobe
                  writeEn_n <= 1'b1;
                  rdata     <= pinDataIn;
                  outEn_n   <= 1'b1;
                  phase     <= 2'h2;
                  count     <= 8'(SETUP);
               end
               default: begin
                  chipEn_n  <= 1'b1;
                  pinDataOe <= 1'b0;
                  busy      <= 1'b0;
                  done      <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/flash_cmd_defs.svh
// Command codes and bus timing counts for the flash command host.
// Assumes a 200 MHz core clock; included by the package and the modules.
`ifndef FLASH_CMD_DEFS_SVH
`define FLASH_CMD_DEFS_SVH

`define CMD_RESET          8'hff
`define CMD_READ           8'h00
`define CMD_PROG_SETUP     8'h40
`define CMD_AUTOSEL_A      8'h80
`define CMD_AUTOSEL_B      8'h90
`define ADDR_MANUF         17'h00000
`define ADDR_DEVICE        17'h00001
`define CLK_PERIOD_PS      5000
`define STROBE_NS          100
`define STROBE_CYC         ((`STROBE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_NS           20
`define SETUP_CYC          ((`SETUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ===== core/flash_cmd_host.sv
// Host controller that issues reset, auto-select, read and program commands to a bulk-erase flash.
// Assumes flash pins are synchronous to core_clk and program supply is switched by an external regulator.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.svh"
module flash_cmd_host
   import flash_cmd_pkg::*;
#(
   parameter int ADDR_W = 17
) (
   input  wire logic              core_clk,
   input  wire logic              rstn,
   input  wire logic              opValid,
   input  wire op_t               opCode,
   input  wire logic [ADDR_W-1:0] opAddr,
   input  wire logic [7:0]        opData,
   input  wire logic              useHighVoltId,
   output logic                   opReady,
   output logic                   opDone,
   output logic [7:0]             opRdata,
   output logic                   opRefused,
   output logic [1:0]             trackState,
   input  wire logic [7:0]        flashDataIn,
   output logic [ADDR_W-1:0]      flashAddr,
   output logic [7:0]             flashDataOut,
   output logic                   flashDataOe,
   output logic                   chipEn_n,
   output logic                   outEn_n,
   output logic                   writeEn_n,
   output logic                   programSupplyHighLevel,
   output logic                   addressBitNineHighVolt
);
   typedef enum logic [1:0] {IDLE, CYCLE, WAITC} seq_t;

   seq_t              seq;
   track_t            track;
   logic              start;
   logic              isWrite;
   logic [ADDR_W-1:0] cycAddr;
   logic [7:0]        cycData;
   logic              secondPending;
   logic              cycBusy;
   logic              cycDone;
   logic [7:0]        cycRdata;

   flash_bus_cycle #(.ADDR_W(ADDR_W)) flash_bus_cycle_i (
      .core_clk   (core_clk),
      .rstn       (rstn),
      .start      (start),
      .isWrite    (isWrite),
      .addr       (cycAddr),
      .wdata      (cycData),
      .pinDataIn  (flashDataIn),
      .pinAddr    (flashAddr),
      .pinDataOut (flashDataOut),
      .pinDataOe  (flashDataOe),
      .chipEn_n   (chipEn_n),
      .outEn_n    (outEn_n),
      .writeEn_n  (writeEn_n),
      .busy       (cycBusy),
      .done       (cycDone),
      .rdata      (cycRdata)
   );

   // Operation sequencer: one or two bus cycles per request, none for a refused write byte
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         seq           <= IDLE;
         start         <= 1'b0;
         isWrite       <= 1'b0;
         cycAddr       <= '0;
         cycData       <= 8'h00;
         secondPending <= 1'b0;
         opReady       <= 1'b0;
         opDone        <= 1'b0;
         opRdata       <= 8'h00;
         opRefused     <= 1'b0;
      end else begin
         start     <= 1'b0;
         opDone    <= 1'b0;
         opRefused <= 1'b0;
         case (seq)
            IDLE: begin
               opReady <= 1'b1;
               if (opValid && opReady) begin
                  opReady       <= 1'b0;
                  secondPending <= 1'b0;
                  cycAddr       <= opAddr;
                  seq           <= CYCLE;
                  case (opCode)
                     OP_RESET: begin
                        isWrite <= 1'b1;
                        cycData <= `CMD_RESET;
                        secondPending <= (track == TRACK_SETUP);
                     end
                     OP_RESET_TWICE: begin
                        isWrite <= 1'b1;
                        cycData <= `CMD_RESET;
                        secondPending <= 1'b1;
                     end
                     OP_AUTOSELECT: begin
                        isWrite <= 1'b1;
                        cycData <= `CMD_AUTOSEL_B;
                     end
                     OP_READ_CMD: begin
                        isWrite <= 1'b1;
                        cycData <= `CMD_READ;
                     end
                     OP_PROG_SETUP: begin
                        isWrite <= 1'b1;
                        cycData <= `CMD_PROG_SETUP;
                     end
                     OP_WRITE_BYTE: begin
                        // Data byte needs setup armed first
                        isWrite <= 1'b1;
                        cycData <= opData;
                        if (track != TRACK_SETUP) begin
                           seq       <= IDLE;
                           opRefused <= 1'b1;
                           opDone    <= 1'b1;
                           opReady   <= 1'b1;
                        end
                     end
                     OP_READ_ID: begin
                        isWrite <= 1'b0;
                        cycAddr <= opAddr[0] ? ADDR_W'(`ADDR_DEVICE) : ADDR_W'(`ADDR_MANUF);
                     end
                     default: begin
                        isWrite <= 1'b0;
                     end
                  endcase
               end
            end
            CYCLE: begin
               start <= 1'b1;
               seq   <= WAITC;
            end
            WAITC: begin
               if (cycDone) begin
                  if (secondPending) begin
                     secondPending <= 1'b0;
                     seq           <= CYCLE;
                  end else begin
                     opRdata <= cycRdata;
                     opDone  <= 1'b1;
                     seq <= IDLE;
                  end
               end
            end
            default: seq <= IDLE;
         endcase
      end
   end

   // Tracks the device's command state after each completed write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         track <= TRACK_READ;
      end else if (cycDone && isWrite) begin
         if (track == TRACK_SETUP)
            track <= TRACK_READ;
         else if (cycData == `CMD_PROG_SETUP)
            track <= TRACK_SETUP;
         else if (cycData == `CMD_AUTOSEL_A || cycData == `CMD_AUTOSEL_B)
            track <= TRACK_AUTOSEL;
         else
            track <= TRACK_READ;
      end
   end

   // Program supply: raised as setup is taken, dropped when a reset op completes
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         programSupplyHighLevel <= 1'b0;
      end else if (seq == IDLE && opValid && opReady && opCode == OP_PROG_SETUP) begin
         programSupplyHighLevel <= 1'b1;
      end else if (seq == WAITC && cycDone && !secondPending && isWrite && cycData == `CMD_RESET) begin
         programSupplyHighLevel <= 1'b0;
      end
   end

   // High voltage on address bit nine only for the length of one id read
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         addressBitNineHighVolt <= 1'b0;
      end else if (seq == IDLE && opValid && opReady && opCode == OP_READ_ID) begin
         addressBitNineHighVolt <= useHighVoltId;
      end else if (seq == WAITC && cycDone && !secondPending) begin
         addressBitNineHighVolt <= 1'b0;
      end
   end

   // Mirror of tracked state for the user
   always_ff @(posedge core_clk) begin
      if (!rstn)
         trackState <= 2'h0;
      else
         trackState <= track;
   end
endmodule
`default_nettype wire

// ===== core/flash_cmd_pkg.sv
// Types shared by the flash command host modules.
// Assumes flash_cmd_defs.svh is on the include path.
`include "flash_cmd_defs.svh"
package flash_cmd_pkg;
   typedef enum logic [2:0] {
      OP_READ,
      OP_RESET,
      OP_RESET_TWICE,
      OP_AUTOSELECT,
      OP_READ_ID,
      OP_PROG_SETUP,
      OP_WRITE_BYTE,
      OP_READ_CMD
   } op_t;
   typedef enum logic [1:0] {
      TRACK_READ,
      TRACK_SETUP,
      TRACK_AUTOSEL
   } track_t;
endpackage

// ===== testbench/flash_cmd_host_properties.sv
// Port checker for the flash command host.
// Assumes one clock domain with a synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_properties #(
   parameter int ADDR_W = 17
) (
   input wire logic              core_clk,
   input wire logic              rstn,
   input wire logic              opValid,
   input wire logic              opReady,
   input wire logic              opDone,
   input wire logic              opRefused,
   input wire logic [1:0]        trackState,
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic [7:0]        flashDataOut,
   input wire logic              flashDataOe,
   input wire logic              chipEn_n,
   input wire logic              outEn_n,
   input wire logic              writeEn_n,
   input wire logic              programSupplyHighLevel,
   input wire logic              addressBitNineHighVolt
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Write strobe framing and latch timing
   property p_wr_frame;
      !writeEn_n |-> !chipEn_n && outEn_n && flashDataOe;
   endproperty
   a_wr_frame: assert property (p_wr_frame) else $error("write strobe outside frame");
   property p_addr_stable;
      !writeEn_n && !$past(writeEn_n) |-> $stable(flashAddr) && $stable(flashDataOut);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address or data moved in strobe");
   property p_strobe_len;
      $fell(writeEn_n) |-> (!writeEn_n && !chipEn_n)[*8];
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("write strobe too short");
   // Request handling
   property p_refused;
      opRefused |-> opDone && writeEn_n && chipEn_n;
   endproperty
   a_refused: assert property (p_refused) else $error("refusal without done or with bus cycle");
   property p_supply;
      $rose(trackState == 2'h1) |-> ##[0:4] programSupplyHighLevel;
   endproperty
   a_supply: assert property (p_supply) else $error("program supply low in setup");
   property p_a9;
      addressBitNineHighVolt |-> writeEn_n;
   endproperty
   a_a9: assert property (p_a9) else $error("high voltage during write");
   property p_reset;
      $rose(rstn) |-> trackState == 2'h0 && writeEn_n && chipEn_n && !opReady;
   endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
   property p_done_pulse;
      opDone |=> !opDone;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_done_bound;
      opValid && opReady |-> ##[1:200] opDone;
   endproperty
   a_done_bound: assert property (p_done_bound) else $error("request never completed");
   // Main scenarios reached
   c_autosel: cover property (trackState == 2'h2);
   c_refused: cover property (opRefused);
   c_highvolt: cover property (addressBitNineHighVolt && !outEn_n);
endmodule
bind flash_cmd_host flash_cmd_host_properties #(.ADDR_W(ADDR_W)) flash_cmd_host_properties_i (.core_clk, .rstn,
   .opValid, .opReady, .opDone, .opRefused, .trackState, .flashAddr, .flashDataOut, .flashDataOe, .chipEn_n,
   .outEn_n, .writeEn_n, .programSupplyHighLevel, .addressBitNineHighVolt);
`default_nettype wire

// ===== testbench/flash_cmd_host_test.sv
// Self-checking bench for the flash command host against a device model.
// Assumes the package, header and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_test;
   import flash_cmd_pkg::*;
   localparam logic [7:0] MANUF = 8'h3c; // Arbitrary value
   localparam logic [7:0] DEVID = 8'hc3; // Arbitrary value
   logic core_clk, rstn, opValid, useHighVoltId, opReady, opDone, opRefused, refusedBit;
   logic flashDataOe, chipEn_n, outEn_n, writeEn_n, programSupplyHighLevel, addressBitNineHighVolt;
   op_t opCode;
   logic [16:0] opAddr, flashAddr;
   logic [7:0] opData, opRdata, flashDataIn, flashDataOut, rdByte;
   logic [1:0] trackState;
   int errors, total_checks, cycles;
   flash_cmd_host #(.ADDR_W(17)) flash_cmd_host_i (.core_clk, .rstn, .opValid, .opCode, .opAddr, .opData,
      .useHighVoltId, .opReady, .opDone, .opRdata, .opRefused, .trackState, .flashDataIn, .flashAddr,
      .flashDataOut, .flashDataOe, .chipEn_n, .outEn_n, .writeEn_n, .programSupplyHighLevel, .addressBitNineHighVolt);
   flash_dev_model #(.MANUF_ID(MANUF), .DEVICE_ID(DEVID)) flash_dev_model_i (.flashAddr, .flashDataOut,
      .flashDataOe, .chipEn_n, .outEn_n, .writeEn_n, .programSupplyHighLevel, .addressBitNineHighVolt, .flashDataIn);
   // Verdict and end of run
   task automatic end_sim;
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Byte and state comparisons
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_track(input logic [1:0] exp);
      chk({6'h0, trackState}, {6'h0, exp});
   endtask
   // One request, held until taken, then wait for done
   task automatic do_op(input op_t op, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      opValid <= 1'b1;
      opCode <= op;
      opAddr <= a;
      opData <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (opReady !== 1'b1 && n < 300);
      opValid <= 1'b0;
      do begin
         @(posedge core_clk);
         n++;
      end while (opDone !== 1'b1 && n < 300);
      rdByte = opRdata;
      refusedBit = opRefused;
      if (n >= 300) chk(8'h00, 8'h01);
      @(posedge core_clk);
   endtask
   // Scenarios
   task automatic t_program;
      do_op(OP_PROG_SETUP, 17'h0, 8'h00);
      chk_track(2'h1);
      chk({7'h0, programSupplyHighLevel}, 8'h01);
      do_op(OP_WRITE_BYTE, 17'h0, 8'h5a);
      chk_track(2'h0);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h5a);
      do_op(OP_PROG_SETUP, 17'h0, 8'h00);
      do_op(OP_WRITE_BYTE, 17'h0, 8'hf0);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h50);
   endtask
   task automatic t_refused;
      do_op(OP_WRITE_BYTE, 17'h5, 8'h00);
      chk({7'h0, refusedBit}, 8'h01);
      do_op(OP_READ, 17'h5, 8'h00);
      chk(rdByte, 8'hff);
   endtask
   task automatic t_setup_reset;
      do_op(OP_PROG_SETUP, 17'h0, 8'h00);
      do_op(OP_RESET, 17'h0, 8'h00);
      chk_track(2'h0);
      chk({7'h0, programSupplyHighLevel}, 8'h00);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h50);
   endtask
   task automatic t_autoselect;
      do_op(OP_AUTOSELECT, 17'h0, 8'h00);
      chk_track(2'h2);
      do_op(OP_READ_ID, 17'h0, 8'h00);
      chk(rdByte, MANUF);
      do_op(OP_READ_ID, 17'h1, 8'h00);
      chk(rdByte, DEVID);
      do_op(OP_READ_ID, 17'h0, 8'h00);
      chk(rdByte, MANUF);
      do_op(OP_RESET, 17'h0, 8'h00);
      chk_track(2'h0);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h50);
      do_op(OP_AUTOSELECT, 17'h0, 8'h00);
      do_op(OP_READ_CMD, 17'h0, 8'h00);
      chk_track(2'h0);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h50);
   endtask
   task automatic t_high_volt;
      useHighVoltId <= 1'b1;
      do_op(OP_READ_ID, 17'h1, 8'h00);
      chk(rdByte, DEVID);
      do_op(OP_READ_ID, 17'h0, 8'h00);
      chk(rdByte, MANUF);
      chk({7'h0, addressBitNineHighVolt}, 8'h00);
      useHighVoltId <= 1'b0;
      do_op(OP_RESET_TWICE, 17'h0, 8'h00);
      chk_track(2'h0);
      do_op(OP_READ, 17'h0, 8'h00);
      chk(rdByte, 8'h50);
   endtask
   // Free running core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Cycle ceiling against hangs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end
   // Reset, then the scenarios in turn
   initial begin
      rstn = 1'b0;
      opValid = 1'b0;
      opCode = OP_READ;
      opAddr = 17'h0;
      opData = 8'h00;
      useHighVoltId = 1'b0;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      chk_track(2'h0);
      chk({7'h0, writeEn_n}, 8'h01);
      t_program();
      t_refused();
      t_setup_reset();
      t_autoselect();
      t_high_volt();
      end_sim();
   end
endmodule
`default_nettype wire

// ===== testbench/flash_dev_model.sv
// Behavioural model of the flash device behind the host pins.
// Assumes a 16 byte array image mirrored over the address space.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
   import flash_cmd_pkg::*;
#(
   parameter logic [7:0] MANUF_ID  = 8'h3c, // Arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'hc3  // Arbitrary value
) (
   input wire logic [16:0] flashAddr,
   input wire logic [7:0]  flashDataOut,
   input wire logic        flashDataOe,
   input wire logic        chipEn_n,
   input wire logic        outEn_n,
   input wire logic        writeEn_n,
   input wire logic        programSupplyHighLevel,
   input wire logic        addressBitNineHighVolt,
   output logic [7:0]      flashDataIn
);
   logic [7:0]  mem [16];
   logic [16:0] latchAddr;
   logic [7:0]  lastOut;
   track_t      mode;
   // Power up erased and in read mode
   initial begin
      mode = TRACK_READ;
      lastOut = 8'h00;
      foreach (mem[i]) mem[i] = 8'hff;
   end
   // Address taken on falling strobe
   always @(negedge writeEn_n) if (!chipEn_n) latchAddr = flashAddr;
   // Command or program byte taken on rising strobe
   always @(posedge writeEn_n) if (!chipEn_n && flashDataOe) begin
      if (mode == TRACK_SETUP) begin
         if (programSupplyHighLevel) mem[latchAddr[3:0]] = mem[latchAddr[3:0]] & flashDataOut;
         mode = TRACK_READ;
      end else case (flashDataOut)
         8'hff, 8'h00: mode = TRACK_READ;
         8'h40: mode = TRACK_SETUP;
         8'h80, 8'h90: mode = TRACK_AUTOSEL;
         default: ;
      endcase
   end
   // Read source from mode or high voltage on address bit nine; released bus shows inverse of last value
   always @* begin
      if (!chipEn_n && !outEn_n) begin
         if (addressBitNineHighVolt || mode == TRACK_AUTOSEL)
            flashDataIn = (flashAddr[16:1] != 16'h0) ? 8'h00 : (flashAddr[0] ? DEVICE_ID : MANUF_ID);
         else flashDataIn = mem[flashAddr[3:0]];
         lastOut = flashDataIn;
      end else flashDataIn = ~lastOut;
   end
endmodule
`default_nettype wire
